// File: buf_map.vh
// Constants of the acceleration sample buffer
`ifndef BUF_MAP_VH
`define BUF_MAP_VH
`define MODE_FIFO 2'h0
`define MODE_STREAM 2'h1
`define MODE_TRIGGER 2'h2
`define MODE_FILO 2'h3
`define DEPTH_SAMPLES 8'h54
`define DEPTH_HIGH_SAMPLES 8'h2A
`define BYTES_HIGH 3'h6
`define BYTES_LOW 3'h3
`define RESET_THRESHOLD 7'h00
`endif

// File: sync3.v
// Three-stage input synchroniser with agreement filter
module sync3 (
	input wire clk,
	input wire rst_n,
	input wire din,
	output reg dout
);
	reg s1;
	reg s2;
	reg s3;
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			s1 <= 1'b0;
			s2 <= 1'b0;
			s3 <= 1'b0;
			dout <= 1'b0;
		end else begin
			s1 <= din;
			s2 <= s1;
			s3 <= s2;
			if (s2 == s3) begin
				dout <= s3;
			end
		end
	end
endmodule // sync3

// File: accel_sample_buffer.v
// Acceleration sample buffer with FIFO, stream, trigger and FILO modes
// Overview of operation
// - Stream and FILO overwrite oldest when full
// - FIFO and trigger stop storing when full
// - Stream and trigger read oldest first
// - Watermark when count reaches a nonzero threshold, except in trigger mode
// - Watermark holds while count at threshold
// - Engine interrupt triggers, keeps pre-trigger samples
// - Pre-trigger: fill to a nonzero threshold, then discard oldest
// - After trigger fill until full, stop
// - Trigger flag when interrupt at threshold count
// - FILO reads newest sample, last byte first
// - Bytes written all at once, six per sample in one cycle
// - Write pointer marks next sample slot
// - FIFO-type read removes oldest, shifts front
// - FILO read removes newest only
// - Above-threshold count from sample count minus threshold
// - Four modes, 8- or 12-bit resolution
// - FIFO reads oldest sample, first byte
// - Capture on a sample strobe when not full or discarding, and not during a clear
`include "buf_map.vh"
module accel_sample_buffer (
	input wire CLK,
	input wire RST_N,
	input wire [1:0] BUFFER_MODE,
	input wire BUFFER_RESOLUTION_SELECT,
	input wire [6:0] SAMPLE_THRESHOLD,
	input wire SAMPLE_STROBE,
	input wire [11:0] SAMPLE_X,
	input wire [11:0] SAMPLE_Y,
	input wire [11:0] SAMPLE_Z,
	input wire ENGINE_INTERRUPT,
	input wire BUFFER_CLEAR,
	input wire READ_BYTE,
	output reg [7:0] READ_DATA,
	output reg READ_VALID,
	output reg WATERMARK,
	output reg TRIGGER_STATUS_FLAG,
	output reg [7:0] BUFFER_BYTE_FILL_LEVEL,
	output reg [7:0] SAMPLES_ABOVE_THRESHOLD
);
	localparam DEPTH = 84;
	reg [7:0] mem_b [0:DEPTH*6-1];
	reg [7:0] count;
	reg [6:0] head;
	reg [6:0] tail;
	reg [2:0] byte_idx;
	reg triggered;
	reg int_prev;
	wire int_sync;
	wire [2:0] bps;
	wire full;
	wire at_th;
	wire discard;
	wire store;
	wire int_rise;
	wire fifo_read;
	reg [6:0] oldest;
	reg [6:0] newest;
	reg [7:0] sel_byte;
	reg [7:0] next_count;
	reg [6:0] next_head;
	reg [6:0] next_tail;
	reg [6:0] wr_slot;
	reg rd_done;
	wire discard_eff;
	reg [7:0] byte_of [0:5];
	integer k;

	// Engine interrupt arrives from outside the clock domain
	sync3 u_int_sync (
		.clk(CLK),
		.rst_n(RST_N),
		.din(ENGINE_INTERRUPT),
		.dout(int_sync)
	);

	assign bps = BUFFER_RESOLUTION_SELECT ? `BYTES_HIGH : `BYTES_LOW;
	// Byte fill level is eight bits, so high resolution holds half the samples
	assign full = BUFFER_RESOLUTION_SELECT ?
		(count == `DEPTH_HIGH_SAMPLES) : (count == `DEPTH_SAMPLES);
	assign at_th = (count >= {1'b0, SAMPLE_THRESHOLD});
	assign int_rise = int_sync & ~int_prev;
	// Stream and FILO discard when full; trigger mode discards pre-trigger once a nonzero threshold reached
	assign discard = ((BUFFER_MODE == `MODE_STREAM ||
		BUFFER_MODE == `MODE_FILO) && full) ||
		(BUFFER_MODE == `MODE_TRIGGER && !triggered &&
		at_th && SAMPLE_THRESHOLD != 7'h00);
	// A sample finished by a read frees a slot, so no discard is needed
	assign discard_eff = discard && !rd_done;
	// Stop storing when full unless discarding, and during a clear
	assign store = SAMPLE_STROBE && !BUFFER_CLEAR &&
		(!full || discard);
	assign fifo_read = (BUFFER_MODE != `MODE_FILO);

	always @* begin
		oldest = tail;
		newest = (head == 7'h00) ? 7'h53 : head - 7'h01;
		byte_of[0] = BUFFER_RESOLUTION_SELECT ?
			{SAMPLE_X[3:0], 4'h0} : SAMPLE_X[11:4];
		byte_of[1] = BUFFER_RESOLUTION_SELECT ?
			SAMPLE_X[11:4] : SAMPLE_Y[11:4];
		byte_of[2] = BUFFER_RESOLUTION_SELECT ?
			{SAMPLE_Y[3:0], 4'h0} : SAMPLE_Z[11:4];
		byte_of[3] = SAMPLE_Y[11:4];
		byte_of[4] = {SAMPLE_Z[3:0], 4'h0};
		byte_of[5] = SAMPLE_Z[11:4];
		// FILO walks bytes from the last, FIFO from the first
		if (fifo_read) begin
			sel_byte = mem_b[oldest*6 + byte_idx];
		end else begin
			sel_byte = mem_b[newest*6 + (bps - 3'h1 - byte_idx)];
		end
	end

	// Pointers and count for the next cycle.
	// Read and store in one cycle both act: the read is applied first,
	// then the store lands on the slot that follows.
	always @* begin
		rd_done = READ_BYTE && (count != 8'h00) &&
			(byte_idx == bps - 3'h1);
		next_head = head;
		next_tail = tail;
		wr_slot = head;
		next_count = count;
		if (rd_done) begin
			next_count = next_count - 8'h01;
			if (fifo_read) begin
				next_tail = (tail == 7'h53) ? 7'h00 :
					tail + 7'h01;
			end else begin
				// Newest goes, older samples stay in place
				next_head = newest;
			end
		end
		if (store) begin
			wr_slot = next_head;
			next_head = (next_head == 7'h53) ? 7'h00 :
				next_head + 7'h01;
			if (discard_eff) begin
				// Oldest sample makes room, count unchanged
				next_tail = (next_tail == 7'h53) ? 7'h00 :
					next_tail + 7'h01;
			end else begin
				next_count = next_count + 8'h01;
			end
		end
	end

	// Sample storage, six byte slots per entry
	// Low resolution uses only the first three byte slots of an entry
	always @(posedge CLK) begin
		if (store) begin
			for (k = 0; k < 6; k = k + 1) begin
				mem_b[wr_slot*6 + k] <= byte_of[k];
			end
		end
	end

	always @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			count <= 8'h00;
			head <= 7'h00;
			tail <= 7'h00;
			byte_idx <= 3'h0;
			triggered <= 1'b0;
			int_prev <= 1'b0;
			READ_DATA <= 8'h00;
			READ_VALID <= 1'b0;
			WATERMARK <= 1'b0;
			TRIGGER_STATUS_FLAG <= 1'b0;
			BUFFER_BYTE_FILL_LEVEL <= 8'h00;
			SAMPLES_ABOVE_THRESHOLD <= 8'h00;
		end else if (BUFFER_CLEAR) begin
			count <= 8'h00;
			head <= 7'h00;
			tail <= 7'h00;
			byte_idx <= 3'h0;
			triggered <= 1'b0;
			int_prev <= int_sync;
			READ_DATA <= 8'h00;
			READ_VALID <= 1'b0;
			WATERMARK <= 1'b0;
			TRIGGER_STATUS_FLAG <= 1'b0;
			BUFFER_BYTE_FILL_LEVEL <= 8'h00;
			SAMPLES_ABOVE_THRESHOLD <= 8'h00;
		end else begin
			int_prev <= int_sync;
			READ_VALID <= READ_BYTE;
			if (READ_BYTE && count == 8'h00) begin
				READ_DATA <= 8'h00;
			end else if (READ_BYTE) begin
				READ_DATA <= sel_byte;
				byte_idx <= (byte_idx == bps - 3'h1) ? 3'h0 :
					byte_idx + 3'h1;
			end
			head <= next_head;
			tail <= next_tail;
			if (BUFFER_MODE == `MODE_TRIGGER && int_rise) begin
				triggered <= 1'b1;
				if (at_th) begin
					TRIGGER_STATUS_FLAG <= 1'b1;
				end
			end
			if (BUFFER_MODE != `MODE_TRIGGER) begin
				triggered <= 1'b0;
			end
			count <= next_count;
			// Watermark is a level, follows the count
			WATERMARK <= (BUFFER_MODE != `MODE_TRIGGER) &&
				SAMPLE_THRESHOLD != 7'h00 &&
				(next_count >= {1'b0, SAMPLE_THRESHOLD});
			BUFFER_BYTE_FILL_LEVEL <= next_count * bps;
			SAMPLES_ABOVE_THRESHOLD <= (next_count >= {1'b0, SAMPLE_THRESHOLD}) ?
				next_count - {1'b0, SAMPLE_THRESHOLD} : 8'h00;
		end
	end
endmodule // accel_sample_buffer

// File: buf_chk_sva.sv
// Port checker for the acceleration sample buffer
module buf_chk (
	input wire CLK,
	input wire RST_N,
	input wire BUFFER_RESOLUTION_SELECT,
	input wire SAMPLE_STROBE,
	input wire BUFFER_CLEAR,
	input wire READ_BYTE,
	input wire [7:0] READ_DATA,
	input wire READ_VALID,
	input wire WATERMARK,
	input wire TRIGGER_STATUS_FLAG,
	input wire [7:0] BUFFER_BYTE_FILL_LEVEL
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge CLK); endclocking
	default disable iff (!RST_N);
	property p_rv; READ_BYTE && !BUFFER_CLEAR |=> READ_VALID; endproperty
	a_rv: assert property (p_rv) else $error("no answer");
	property p_nv; !READ_BYTE |=> !READ_VALID; endproperty
	a_nv: assert property (p_nv) else $error("stray answer");
	property p_clr; BUFFER_CLEAR |=> BUFFER_BYTE_FILL_LEVEL == 8'h00
		&& !WATERMARK && !TRIGGER_STATUS_FLAG; endproperty
	a_clr: assert property (p_clr) else $error("clear");
	property p_tf; TRIGGER_STATUS_FLAG && !BUFFER_CLEAR |=>
		TRIGGER_STATUS_FLAG; endproperty
	a_tf: assert property (p_tf) else $error("flag lost");
	property p_st; (!SAMPLE_STROBE && !READ_BYTE && !BUFFER_CLEAR)[*2]
		|=> $stable(BUFFER_BYTE_FILL_LEVEL); endproperty
	a_st: assert property (p_st) else $error("level moved");
	property p_er; READ_BYTE && BUFFER_BYTE_FILL_LEVEL == 8'h00
		&& !SAMPLE_STROBE && !$past(SAMPLE_STROBE) |=> READ_DATA == 8'h00;
	endproperty
	a_er: assert property (p_er) else $error("empty read");
	property p_hr; BUFFER_RESOLUTION_SELECT && $past(BUFFER_RESOLUTION_SELECT)
		|-> BUFFER_BYTE_FILL_LEVEL % 6 == 0; endproperty
	a_hr: assert property (p_hr) else $error("partial");
	property p_wf; WATERMARK |-> BUFFER_BYTE_FILL_LEVEL != 8'h00; endproperty
	a_wf: assert property (p_wf) else $error("watermark");
	c_wm: cover property (WATERMARK);
	c_tf: cover property (TRIGGER_STATUS_FLAG);
	c_rv: cover property (READ_VALID && READ_DATA != 8'h00);
endmodule // buf_chk
bind accel_sample_buffer buf_chk i_buf_chk (.CLK, .RST_N,
	.BUFFER_RESOLUTION_SELECT, .SAMPLE_STROBE, .BUFFER_CLEAR, .READ_BYTE,
	.READ_DATA, .READ_VALID, .WATERMARK, .TRIGGER_STATUS_FLAG,
	.BUFFER_BYTE_FILL_LEVEL);

// File: host_reader.sv
// Host model that pulls bytes out of the buffer
module host_reader (
	input wire CLK,
	output logic READ_BYTE
);
	timeunit 1ns;
	timeprecision 1ns;
	initial READ_BYTE = 1'h0;
	task rd(input int n);
		repeat (n) @(negedge CLK) READ_BYTE = 1'h1;
		@(negedge CLK) READ_BYTE = 1'h0;
	endtask
endmodule // host_reader

// File: tb_accel_sample_buffer.sv
// Self-checking bench for the acceleration sample buffer
`include "buf_map.vh"
module tb_accel_sample_buffer;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk = 0, rst_n = 0, res = 0, stb = 0, irq = 0, clr = 0;
	logic rd, wm, tf, rv;
	logic [7:0] sat;
	logic [1:0] mode = 0;
	logic [6:0] thr = 0;
	logic [7:0] k = 0, rdata, fill;
	int failures = 0, compares = 0, i;
	typedef struct {logic [1:0] m; logic r; logic [6:0] t; int n;
		logic [7:0] f; logic w; logic [7:0] b; logic [7:0] a;} row_t;
	row_t rows[6] = '{
		'{`MODE_FIFO, 1'h1, 7'h03, 2, 8'h0C, 1'h0, 8'h10, 8'h00},
		'{`MODE_STREAM, 1'h0, 7'h02, 2, 8'h06, 1'h1, 8'h01, 8'h00},
		'{`MODE_FILO, 1'h1, 7'h02, 3, 8'h12, 1'h1, 8'h83, 8'h01},
		'{`MODE_TRIGGER, 1'h0, 7'h02, 4, 8'h06, 1'h0, 8'h03, 8'h00},
		'{`MODE_FIFO, 1'h0, 7'h02, 90, 8'hFC, 1'h1, 8'h01, 8'h52},
		'{`MODE_STREAM, 1'h0, 7'h00, 90, 8'hFC, 1'h0, 8'h07, 8'h54}};
	accel_sample_buffer i_accel_sample_buffer (.CLK(clk), .RST_N(rst_n),
		.BUFFER_MODE(mode), .BUFFER_RESOLUTION_SELECT(res),
		.SAMPLE_THRESHOLD(thr), .SAMPLE_STROBE(stb), .SAMPLE_X({k, 4'h1}),
		.SAMPLE_Y({k, 4'h3}), .SAMPLE_Z({k ^ 8'h80, 4'h2}),
		.ENGINE_INTERRUPT(irq), .BUFFER_CLEAR(clr), .READ_BYTE(rd),
		.READ_DATA(rdata), .READ_VALID(rv), .WATERMARK(wm),
		.TRIGGER_STATUS_FLAG(tf), .BUFFER_BYTE_FILL_LEVEL(fill),
		.SAMPLES_ABOVE_THRESHOLD(sat));
	host_reader i_host_reader (.CLK(clk), .READ_BYTE(rd));
	task chk(input logic [7:0] got, exp);
		compares++;
		if (got !== exp) begin
			failures++;
			$display("BAD %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task setup(input logic [1:0] m, input logic r, input logic [6:0] t);
		@(negedge clk) clr = 1;
		mode = m;
		res = r;
		thr = t;
		k = 0;
		@(negedge clk) clr = 0;
	endtask
	task put(input int n);
		repeat (n) begin
			@(negedge clk) stb = 1;
			k = k + 8'h01;
			@(negedge clk) stb = 0;
		end
		@(negedge clk);
	endtask
	task first(input logic [7:0] exp);
		i_host_reader.rd(1);
		chk({7'h00, rv}, 8'h01);
		@(negedge clk);
		chk(rdata, exp);
		chk({7'h00, rv}, 8'h00);
	endtask
	task final_report;
		$display("compares %0d failures %0d", compares, failures);
		if (failures == 0 && compares > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	initial begin
		forever #25 clk = ~clk;
	end
	initial begin
		repeat (6) @(negedge clk);
		rst_n = 1;
		chk(fill, 8'h00);
		foreach (rows[j]) begin
			setup(rows[j].m, rows[j].r, rows[j].t);
			put(rows[j].n);
			chk(fill, rows[j].f);
			chk(sat, rows[j].a);
			chk({7'h00, wm}, {7'h00, rows[j].w});
			first(rows[j].b);
			$display("row %0d done", j);
		end
		setup(`MODE_FILO, 1'h0, 7'h00);
		put(3);
		i_host_reader.rd(3);
		@(negedge clk);
		chk(fill, 8'h06);
		first(8'h82);
		$display("filo removal done");
		setup(`MODE_TRIGGER, 1'h0, 7'h02);
		put(3);
		irq = 1;
		for (i = 0; i < 20 && tf !== 1'h1; i++) @(negedge clk);
		chk({7'h00, tf}, 8'h01);
		if (tf !== 1'h1) final_report;
		put(90);
		chk(fill, 8'hFC);
		first(8'h02);
		irq = 0;
		setup(`MODE_FIFO, 1'h0, 7'h02);
		@(negedge clk);
		chk(fill | {7'h00, tf}, 8'h00);
		first(8'h00);
		$display("trigger and clear done");
		final_report;
	end
endmodule // tb_accel_sample_buffer
